// >>> cit_pkg.sv
package cit_pkg;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        S_FETCH = 2'b01,
        S_EXEC  = 2'b10
    } cit_state_t;

    // Instruction classes, taken from opcode bits [4:0]
    typedef enum logic [4:0] {
        CL_ARITH_REG   = 5'h00,
        CL_ARITH_DIR   = 5'h01,
        CL_ARITH_IND   = 5'h02,
        CL_ARITH_IMM   = 5'h03,
        CL_PRODUCT     = 5'h04,
        CL_QUOTIENT    = 5'h05,
        CL_MOV_DIR_DIR = 5'h06,
        CL_MOV_DIR_IMM = 5'h07,
        CL_MOV_REG_DIR = 5'h08,
        CL_MOV_DIR_IND = 5'h09,
        CL_MOV_IND_ACC = 5'h0A,
        CL_MOV_IND_DIR = 5'h0B,
        CL_LOAD_PTR16  = 5'h0C,
        CL_CODE_PTR16  = 5'h0D,
        CL_CODE_PC     = 5'h0E,
        CL_XRD_REG8    = 5'h0F,
        CL_XRD_PTR16   = 5'h10,
        CL_XWR_REG8    = 5'h11,
        CL_XWR_PTR16   = 5'h12,
        CL_STACK_PUSH  = 5'h13,
        CL_STACK_POP   = 5'h14,
        CL_SWAP_DIR    = 5'h15,
        CL_NIBBLE_SWAP = 5'h16,
        CL_BIT_AND_C   = 5'h17
    } cit_class_t;

    localparam int          NUM_CLASS   = 24;
    localparam logic [4:0]  CLASS_LAST  = 5'h17;
    localparam int          OP_CLASS_HI = 4;
    localparam int          OP_ARITH_HI = 6;
    localparam int          OP_ARITH_LO = 5;

    // Arithmetic operation select, opcode bits [6:5]
    localparam logic [1:0]  AR_ADD      = 2'h0;
    localparam logic [1:0]  AR_ADD_CARRY  = 2'h1;
    localparam logic [1:0]  AR_SUB_BORROW = 2'h2;
    localparam logic [1:0]  AR_BAD      = 2'h3;

    // Byte lengths and cycle counts
    localparam logic [1:0]  L1 = 2'h1;
    localparam logic [1:0]  L2 = 2'h2;
    localparam logic [1:0]  L3 = 2'h3;
    localparam logic [2:0]  C1 = 3'h1;
    localparam logic [2:0]  C2 = 3'h2;
    localparam logic [2:0]  C3 = 3'h3;
    localparam logic [2:0]  C4 = 3'h4;
    localparam logic [2:0]  C5 = 3'h5;
    localparam logic [2:0]  C6 = 3'h6;
    localparam logic [2:0]  CNT_MAX = 3'h7;

    // Length per class, index 23 on the left
    localparam logic [NUM_CLASS-1:0][1:0] LEN_TAB = {
        L2, L1, L2, L2, L2, L1, L1, L1, L1, L1, L1, L3,
        L2, L1, L2, L2, L3, L3, L1, L1, L2, L1, L2, L1
    };

    // Cycles per class, index 23 on the left
    localparam logic [NUM_CLASS-1:0][2:0] CYC_TAB = {
        C2, C3, C3, C2, C3, C4, C5, C3, C4, C4, C5, C3,
        C3, C2, C3, C3, C3, C3, C6, C2, C2, C2, C2, C1
    };

    localparam logic [15:0] PC_RESET  = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

endpackage

// >>> cit_dec_if.sv
`timescale 1ns/100ps
`default_nettype none

// Opcode in, decoded timing out
interface cit_dec_if;
    logic [7:0]         opcode;
    cit_pkg::cit_class_t iclass;
    logic [1:0]         arith_op;
    logic [1:0]         ilen;
    logic [2:0]         icycles;
    logic               illegal;

    modport dec (
        input  opcode,
        output iclass,
        output arith_op,
        output ilen,
        output icycles,
        output illegal
    );

    modport core (
        output opcode,
        input  iclass,
        input  arith_op,
        input  ilen,
        input  icycles,
        input  illegal
    );
endinterface

`default_nettype wire

// >>> cit_decode.sv
`timescale 1ns/100ps
`default_nettype none

module cit_decode (
    // Decode port
    cit_dec_if.dec d
);

    logic [4:0] cls_idx;
    logic       arith_cls;
    logic       cls_ok;
    logic       bad;

    // Class lookup; unknown codes run as one byte, one cycle
    assign cls_idx   = d.opcode[cit_pkg::OP_CLASS_HI:0];
    assign cls_ok    = (cls_idx <= cit_pkg::CLASS_LAST);
    assign arith_cls = (cls_idx <= cit_pkg::CL_ARITH_IMM);
    assign d.arith_op = d.opcode[cit_pkg::OP_ARITH_HI:cit_pkg::OP_ARITH_LO];
    assign bad       = !cls_ok || (arith_cls && d.arith_op == cit_pkg::AR_BAD);
    assign d.illegal = bad;
    assign d.iclass  = cit_pkg::cit_class_t'(cls_ok ? cls_idx : 5'h00);
    // Tables indexed by the clamped class so no read falls past entry 23
    assign d.ilen    = bad ? cit_pkg::L1 : cit_pkg::LEN_TAB[d.iclass];
    assign d.icycles = bad ? cit_pkg::C1 : cit_pkg::CYC_TAB[d.iclass];

endmodule

`default_nettype wire

// >>> cit_core.sv
// Summary of operation
// - Add, add-carry, subtract-borrow from working register: one byte, one cycle.
// - Same three with direct byte source: two bytes, two cycles.
// - Same three with indirect internal RAM source: one byte, two cycles.
// - Same three with immediate operand: two bytes, two cycles.
// - Multiply accumulator by B: one byte, two cycles.
// - Divide accumulator by B: one byte, six cycles.
// - Direct to direct byte copy: three bytes, three cycles.
// - Immediate to direct byte store: three bytes, three cycles.
// - Load working register from direct byte: two bytes, three cycles.
// - Indirect RAM to direct byte copy: two bytes, three cycles.
// - Accumulator to indirect RAM store: one byte, two cycles.
// - Direct byte to indirect RAM copy: two bytes, three cycles.
// - Load 16-bit data pointer from constant: three bytes, three cycles.
// - Code byte at accumulator plus data pointer: one byte, five cycles.
// - Code byte at accumulator plus program counter: one byte, four cycles.
// - External RAM read: four cycles 8-bit address, three cycles 16-bit.
// - External RAM write: five cycles 8-bit address, four cycles 16-bit.
// - Push three cycles, pop two cycles, both two bytes.
// - Swap direct byte with accumulator: two bytes, three cycles.
// - Swap low digit of indirect RAM with accumulator: one byte, three cycles.
// - AND direct bit into carry: two bytes, two cycles.
`timescale 1ns/100ps
`default_nettype none

module cit_core (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Program memory
    output logic             fetch_req,
    output logic [15:0]      code_addr,
    input  wire logic [7:0]  code_rdata,
    input  wire logic        code_valid,
    // Instruction status
    output logic             instr_done,
    output logic             busy,
    output logic             illegal,
    output logic [4:0]       instr_class,
    output logic [1:0]       arith_op,
    output logic [1:0]       instr_len,
    output logic [2:0]       instr_cycles,
    output logic [7:0]       operand1,
    output logic [7:0]       operand2
);

    cit_dec_if dif ();

    cit_pkg::cit_state_t state_reg;
    cit_pkg::cit_state_t state_next;
    logic        fetch_reg;
    logic        fetch_next;
    logic        done_reg;
    logic        done_next;
    logic [15:0] pc_reg;
    logic [2:0]  cnt_reg;
    logic [2:0]  cnt_next;
    logic [1:0]  left_reg;
    logic [1:0]  left_next;
    logic [1:0]  len_reg;
    logic [2:0]  cyc_reg;
    logic [4:0]  class_reg;
    logic [1:0]  aop_reg;
    logic        bad_reg;
    logic [7:0]  opnd1_reg;
    logic [7:0]  opnd2_reg;

    logic        st_fetch;
    logic        st_exec;
    logic        take;
    logic        op_take;
    logic        ex_take;
    logic        one_shot;
    logic [1:0]  left_after;
    logic [2:0]  cnt_inc;
    logic        exec_end;
    logic        first_opnd;

    cit_decode u_dec (
        .d (dif.dec)
    );

    // Decode the byte on the bus; only used when an opcode is taken
    assign dif.opcode = code_rdata;

    // Handshake and state decode
    assign st_fetch   = (state_reg == cit_pkg::S_FETCH);
    assign st_exec    = (state_reg == cit_pkg::S_EXEC);
    assign take       = fetch_reg && code_valid;
    assign op_take    = take && st_fetch;
    assign ex_take    = take && st_exec;
    assign one_shot   = op_take && dif.ilen == cit_pkg::L1 && dif.icycles == cit_pkg::C1;
    assign left_after = ex_take ? left_reg - cit_pkg::L1 : left_reg;
    assign cnt_inc    = (cnt_reg == cit_pkg::CNT_MAX) ? cnt_reg : cnt_reg + cit_pkg::C1;
    // End needs both the cycle budget spent and every byte in
    assign exec_end   = st_exec && cnt_inc >= cyc_reg && left_after == 2'h0;
    assign first_opnd = (left_reg + cit_pkg::L1 == len_reg);

    // Next state; a one-cycle instruction never leaves fetch
    always_comb begin
        case (state_reg)
            cit_pkg::S_FETCH: begin
                state_next = (op_take && !one_shot) ? cit_pkg::S_EXEC : cit_pkg::S_FETCH;
            end
            cit_pkg::S_EXEC: begin
                state_next = exec_end ? cit_pkg::S_FETCH : cit_pkg::S_EXEC;
            end
            default: begin
                state_next = cit_pkg::S_FETCH; // Stray code recovers to fetch
            end
        endcase
    end
    // Hold off the next opcode request until the count has elapsed
    assign fetch_next = st_fetch ? (!op_take || one_shot || dif.ilen != cit_pkg::L1)
                                 : (exec_end || left_after != 2'h0);
    assign done_next  = one_shot || exec_end;
    assign cnt_next   = op_take ? cit_pkg::C1 : cnt_inc;
    assign left_next  = op_take ? dif.ilen - cit_pkg::L1 : left_after;

    // Sequencer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= cit_pkg::S_FETCH;
            fetch_reg <= 1'b0;
            done_reg  <= 1'b0;
            cnt_reg   <= cit_pkg::C1;
            left_reg  <= 2'h0;
        end else begin
            state_reg <= state_next;
            fetch_reg <= fetch_next;
            done_reg  <= done_next;
            cnt_reg   <= cnt_next;
            left_reg  <= left_next;
        end
    end

    // Program counter advances once per byte taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= cit_pkg::PC_RESET;
        end else if (take) begin
            pc_reg <= pc_reg + 16'h0001;
        end
    end

    // Decoded timing, latched with the opcode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            len_reg   <= cit_pkg::L1;
            cyc_reg   <= cit_pkg::C1;
            class_reg <= 5'h00;
            aop_reg   <= cit_pkg::AR_ADD;
            bad_reg   <= 1'b0;
        end else if (op_take) begin
            len_reg   <= dif.ilen;
            cyc_reg   <= dif.icycles;
            class_reg <= dif.iclass;
            aop_reg   <= dif.arith_op;
            bad_reg   <= dif.illegal;
        end
    end

    // Operand bytes in fetch order
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            opnd1_reg <= cit_pkg::BYTE_ZERO;
            opnd2_reg <= cit_pkg::BYTE_ZERO;
        end else if (op_take) begin
            opnd1_reg <= cit_pkg::BYTE_ZERO;
            opnd2_reg <= cit_pkg::BYTE_ZERO;
        end else if (ex_take && first_opnd) begin
            opnd1_reg <= code_rdata;
        end else if (ex_take) begin
            opnd2_reg <= code_rdata;
        end
    end

    // Outputs straight from flops
    assign fetch_req    = fetch_reg;
    assign code_addr    = pc_reg;
    assign instr_done   = done_reg;
    assign busy         = state_reg[1];
    assign illegal      = bad_reg;
    assign instr_class  = class_reg;
    assign arith_op     = aop_reg;
    assign instr_len    = len_reg;
    assign instr_cycles = cyc_reg;
    assign operand1     = opnd1_reg;
    assign operand2     = opnd2_reg;

    // Checking aids: span since opcode, bytes taken, stall seen
    // Span saturates so a long stall cannot wrap round and fake a match
    logic [2:0] span_reg;
    logic [1:0] nbytes_reg;
    logic       stall_reg;
    logic       clean_done;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            span_reg   <= cit_pkg::CNT_MAX;
            nbytes_reg <= 2'h0;
            stall_reg  <= 1'b0;
        end else begin
            span_reg   <= op_take ? cit_pkg::C1 : cnt_inc_span(span_reg);
            nbytes_reg <= op_take ? cit_pkg::L1 : (ex_take ? nbytes_reg + 2'h1 : nbytes_reg);
            stall_reg  <= op_take ? 1'b0 : (stall_reg || (st_exec && fetch_reg && !code_valid));
        end
    end

    function automatic logic [2:0] cnt_inc_span(input logic [2:0] v);
        cnt_inc_span = (v == cit_pkg::CNT_MAX) ? v : v + cit_pkg::C1;
    endfunction

    // Exact timing is checked only when memory did not stall
    assign clean_done = done_reg && !stall_reg && !bad_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_arith_reg_time: assert property (
        clean_done && class_reg == cit_pkg::CL_ARITH_REG |-> span_reg == 3'h1 && nbytes_reg == 2'h1)
        else $error("register arithmetic timing wrong");
    a_arith_dir_time: assert property (
        clean_done && class_reg == cit_pkg::CL_ARITH_DIR |-> span_reg == 3'h2 && nbytes_reg == 2'h2)
        else $error("direct arithmetic timing wrong");
    a_arith_ind_time: assert property (
        clean_done && class_reg == cit_pkg::CL_ARITH_IND |-> span_reg == 3'h2 && nbytes_reg == 2'h1)
        else $error("indirect arithmetic timing wrong");
    a_arith_imm_time: assert property (
        clean_done && class_reg == cit_pkg::CL_ARITH_IMM |-> span_reg == 3'h2 && nbytes_reg == 2'h2)
        else $error("immediate arithmetic timing wrong");
    a_product_time: assert property (
        clean_done && class_reg == cit_pkg::CL_PRODUCT |-> span_reg == 3'h2 && nbytes_reg == 2'h1)
        else $error("multiply timing wrong");
    a_quotient_time: assert property (
        op_take && dif.iclass == cit_pkg::CL_QUOTIENT && !dif.illegal && code_valid
        |-> ##6 instr_done)
        else $error("divide did not end after six cycles");
    a_dir_dir_time: assert property (
        clean_done && class_reg == cit_pkg::CL_MOV_DIR_DIR |-> span_reg == 3'h3 && nbytes_reg == 2'h3)
        else $error("direct copy timing wrong");
    a_dir_imm_time: assert property (
        clean_done && class_reg == cit_pkg::CL_MOV_DIR_IMM |-> span_reg == 3'h3 && nbytes_reg == 2'h3)
        else $error("immediate store timing wrong");
    a_reg_dir_time: assert property (
        clean_done && class_reg == cit_pkg::CL_MOV_REG_DIR |-> span_reg == 3'h3 && nbytes_reg == 2'h2)
        else $error("register load timing wrong");
    a_dir_ind_time: assert property (
        clean_done && class_reg == cit_pkg::CL_MOV_DIR_IND |-> span_reg == 3'h3 && nbytes_reg == 2'h2)
        else $error("indirect to direct timing wrong");
    a_ind_acc_time: assert property (
        clean_done && class_reg == cit_pkg::CL_MOV_IND_ACC |-> span_reg == 3'h2 && nbytes_reg == 2'h1)
        else $error("accumulator store timing wrong");
    a_ind_dir_time: assert property (
        clean_done && class_reg == cit_pkg::CL_MOV_IND_DIR |-> span_reg == 3'h3 && nbytes_reg == 2'h2)
        else $error("direct to indirect timing wrong");
    a_ptr_load_time: assert property (
        clean_done && class_reg == cit_pkg::CL_LOAD_PTR16 |-> span_reg == 3'h3 && nbytes_reg == 2'h3)
        else $error("pointer load timing wrong");
    a_code_ptr_time: assert property (
        clean_done && class_reg == cit_pkg::CL_CODE_PTR16 |-> span_reg == 3'h5 && nbytes_reg == 2'h1)
        else $error("pointer code read timing wrong");
    a_code_pc_time: assert property (
        clean_done && class_reg == cit_pkg::CL_CODE_PC |-> span_reg == 3'h4 && nbytes_reg == 2'h1)
        else $error("counter code read timing wrong");
    a_xram_read_time: assert property (
        clean_done && (class_reg == cit_pkg::CL_XRD_REG8 || class_reg == cit_pkg::CL_XRD_PTR16)
        |-> nbytes_reg == 2'h1 && !busy &&
        span_reg == (class_reg == cit_pkg::CL_XRD_REG8 ? 3'h4 : 3'h3))
        else $error("external read timing wrong");
    a_xram_write_time: assert property (
        op_take && dif.iclass == cit_pkg::CL_XWR_REG8 && !dif.illegal |=> busy [*4] ##1 !busy)
        else $error("external 8-bit write timing wrong");
    a_stack_ops_time: assert property (
        clean_done && (class_reg == cit_pkg::CL_STACK_PUSH || class_reg == cit_pkg::CL_STACK_POP)
        |-> nbytes_reg == 2'h2 && span_reg == (class_reg == cit_pkg::CL_STACK_PUSH ? 3'h3 : 3'h2))
        else $error("stack timing wrong");
    a_swap_dir_time: assert property (
        clean_done && class_reg == cit_pkg::CL_SWAP_DIR |-> span_reg == 3'h3 && nbytes_reg == 2'h2)
        else $error("swap timing wrong");
    a_nibble_swap_time: assert property (
        clean_done && class_reg == cit_pkg::CL_NIBBLE_SWAP |-> span_reg == 3'h3 && nbytes_reg == 2'h1)
        else $error("digit swap timing wrong");
    a_bit_and_time: assert property (
        clean_done && class_reg == cit_pkg::CL_BIT_AND_C |-> span_reg == 3'h2 && nbytes_reg == 2'h2)
        else $error("bit and timing wrong");
    a_no_early_fetch: assert property (
        op_take |-> span_reg >= cyc_reg && (instr_done || !$past(busy)))
        else $error("opcode fetched before cycle count elapsed");
    // Sequencing guards beyond the per-class timing
    a_exec_no_fetch: assert property (
        busy && instr_len == cit_pkg::L1 |-> !fetch_req)
        else $error("code byte requested while one-byte instruction runs");
    a_illegal_short: assert property (
        done_reg && bad_reg |-> span_reg == 3'h1 && nbytes_reg == 2'h1)
        else $error("unknown opcode did not run as one byte one cycle");
    a_pc_step: assert property (
        take |=> code_addr == $past(code_addr) + 16'h0001)
        else $error("code address did not step by one per byte");

endmodule

`default_nettype wire

// >>> cit_tb.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;

    // Clock, reset and program memory side
    logic        mclk;
    logic        rst_n;
    logic        code_valid;
    logic [7:0]  code_rdata;
    logic [7:0]  prog [0:255];
    // Core outputs
    logic        fetch_req;
    logic [15:0] code_addr;
    logic        instr_done;
    logic        busy;
    logic        illegal;
    logic [4:0]  instr_class;
    logic [1:0]  arith_op;
    logic [1:0]  instr_len;
    logic [2:0]  instr_cycles;
    logic [7:0]  operand1;
    logic [7:0]  operand2;
    // Bench bookkeeping
    int          checks;
    int          n_fail;
    logic [15:0] exp_pc;

    cit_core i_dut (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .fetch_req    (fetch_req),
        .code_addr    (code_addr),
        .code_rdata   (code_rdata),
        .code_valid   (code_valid),
        .instr_done   (instr_done),
        .busy         (busy),
        .illegal      (illegal),
        .instr_class  (instr_class),
        .arith_op     (arith_op),
        .instr_len    (instr_len),
        .instr_cycles (instr_cycles),
        .operand1     (operand1),
        .operand2     (operand2)
    );

    // Zero-wait code memory; only 256 bytes, the run never wraps
    assign code_rdata = prog[code_addr[7:0]];

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic timeout();
        n_fail++;
        $display("unexpected at %0t: wait bound used up", $time);
        close_out();
    endtask

    // Outputs while reset is held
    task automatic check_reset_vals();
        check("fetch_req", 16'(fetch_req), 16'h0000);
        check("done", 16'(instr_done), 16'h0000);
        check("busy", 16'(busy), 16'h0000);
        check("illegal", 16'(illegal), 16'h0000);
        check("class", 16'(instr_class), 16'h0000);
        check("length", 16'(instr_len), 16'h0001);
        check("cycles", 16'(instr_cycles), 16'h0001);
        check("operands", {operand1, operand2}, 16'h0000);
    endtask

    // Entered at a falling edge; places one instruction at the expected PC,
    // times it from opcode take to done, and leaves at the done cycle so the
    // next opcode take is not missed
    task automatic run_instr(input logic [7:0] op, input logic [1:0] len, input logic [2:0] cyc,
                             input logic ill, input int stall, input int ext);
        logic [15:0] pc0;
        int          t;
        int          nb;
        pc0 = exp_pc;
        prog[pc0[7:0]] = op;
        prog[8'(pc0 + 16'h0001)] = op ^ 8'hA5;
        prog[8'(pc0 + 16'h0002)] = op ^ 8'h5A;
        for (t = 0; t < 40; t++) begin
            if (fetch_req === 1'b1 && code_valid === 1'b1) break;
            @(posedge mclk);
            @(negedge mclk);
        end
        if (t == 40) timeout();
        check("opcode address", code_addr, pc0);
        @(posedge mclk);
        if (stall > 0) code_valid <= 1'b0;
        nb = 0;
        for (t = 1; t < 40; t++) begin
            @(negedge mclk);
            if (instr_done === 1'b1) break;
            if (fetch_req === 1'b1 && code_valid === 1'b1) nb++;
            @(posedge mclk);
            if (t == stall) code_valid <= 1'b1;
        end
        if (t == 40) timeout();
        check("cycles to done", 16'(t), 16'(cyc) + 16'(ext));
        check("operand bytes", 16'(nb), 16'(len) - 16'h0001);
        check("length", 16'(instr_len), 16'(len));
        check("cycle count", 16'(instr_cycles), 16'(cyc));
        check("illegal", 16'(illegal), 16'(ill));
        check("class", 16'(instr_class), 16'(op[4:0] > 5'h17 ? 5'h00 : op[4:0]));
        if (op[4:2] == 3'h0) check("arith op", 16'(arith_op), 16'(op[6:5]));
        check("operand1", 16'(operand1), len > 2'h1 ? 16'(op ^ 8'hA5) : 16'h0000);
        check("operand2", 16'(operand2), len == 2'h3 ? 16'(op ^ 8'h5A) : 16'h0000);
        check("busy at done", 16'(busy), 16'h0000);
        check("next fetch", 16'(fetch_req), 16'h0001);
        exp_pc = pc0 + 16'(len);
        check("next address", code_addr, exp_pc);
    endtask

    // All three arithmetic operations of one addressing form, back to back
    task automatic arith_form(input logic [4:0] cl, input logic [1:0] len, input logic [2:0] cyc);
        for (int k = 0; k < 3; k++) begin
            run_instr({1'b0, 2'(k), cl}, len, cyc, 1'b0, 0, 0);
        end
    endtask

    task automatic test_reset();
        @(negedge mclk);
        check_reset_vals();
        @(posedge mclk);
        rst_n <= 1'b1;
        code_valid <= 1'b1;
        @(negedge mclk);
        check("fetch before first edge", 16'(fetch_req), 16'h0000);
        @(negedge mclk);
        check("fetch after first edge", 16'(fetch_req), 16'h0001);
        $display("test reset done");
    endtask

    task automatic test_arith();
        arith_form(5'h00, 2'h1, 3'h1);
        arith_form(5'h01, 2'h2, 3'h2);
        arith_form(5'h02, 2'h1, 3'h2);
        arith_form(5'h03, 2'h2, 3'h2);
        $display("test arith done");
    endtask

    // One instruction per class from 0x04 to 0x17, in class order
    task automatic test_transfer();
        run_instr(8'h04, 2'h1, 3'h2, 1'b0, 0, 0);
        run_instr(8'h85, 2'h1, 3'h6, 1'b0, 0, 0);
        run_instr(8'h06, 2'h3, 3'h3, 1'b0, 0, 0);
        run_instr(8'h07, 2'h3, 3'h3, 1'b0, 0, 0);
        run_instr(8'h08, 2'h2, 3'h3, 1'b0, 0, 0);
        run_instr(8'h09, 2'h2, 3'h3, 1'b0, 0, 0);
        run_instr(8'h0A, 2'h1, 3'h2, 1'b0, 0, 0);
        run_instr(8'h0B, 2'h2, 3'h3, 1'b0, 0, 0);
        run_instr(8'h0C, 2'h3, 3'h3, 1'b0, 0, 0);
        run_instr(8'h0D, 2'h1, 3'h5, 1'b0, 0, 0);
        run_instr(8'h0E, 2'h1, 3'h4, 1'b0, 0, 0);
        run_instr(8'h0F, 2'h1, 3'h4, 1'b0, 0, 0);
        run_instr(8'h10, 2'h1, 3'h3, 1'b0, 0, 0);
        run_instr(8'h11, 2'h1, 3'h5, 1'b0, 0, 0);
        run_instr(8'h12, 2'h1, 3'h4, 1'b0, 0, 0);
        run_instr(8'h13, 2'h2, 3'h3, 1'b0, 0, 0);
        run_instr(8'h14, 2'h2, 3'h2, 1'b0, 0, 0);
        run_instr(8'h15, 2'h2, 3'h3, 1'b0, 0, 0);
        run_instr(8'h16, 2'h1, 3'h3, 1'b0, 0, 0);
        run_instr(8'h17, 2'h2, 3'h2, 1'b0, 0, 0);
        $display("test transfer done");
    endtask

    // Unknown classes and the spare arithmetic select run as 1 byte, 1 cycle
    task automatic test_illegal();
        run_instr(8'h18, 2'h1, 3'h1, 1'b1, 0, 0);
        run_instr(8'h60, 2'h1, 3'h1, 1'b1, 0, 0);
        run_instr(8'h1F, 2'h1, 3'h1, 1'b1, 0, 0);
        $display("test illegal done");
    endtask

    // Memory holds back operands; during a divide the lull must be ignored
    task automatic test_stall();
        run_instr(8'h06, 2'h3, 3'h3, 1'b0, 2, 2);
        run_instr(8'h05, 2'h1, 3'h6, 1'b0, 3, 0);
        run_instr(8'h01, 2'h2, 3'h2, 1'b0, 1, 1);
        $display("test stall done");
    endtask

    // Reset in the middle of a divide, then restart from address zero
    task automatic test_reset_mid();
        prog[exp_pc[7:0]] = 8'h05;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b0;
        @(negedge mclk);
        check_reset_vals();
        check("pc after reset", code_addr, 16'h0000);
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        exp_pc = 16'h0000;
        run_instr(8'h20, 2'h1, 3'h1, 1'b0, 0, 0);
        run_instr(8'h0C, 2'h3, 3'h3, 1'b0, 0, 0);
        $display("test reset_mid done");
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        code_valid = 1'b0;
        checks = 0;
        n_fail = 0;
        exp_pc = 16'h0000;
        for (int i = 0; i < 256; i++) begin
            prog[i] = 8'h00;
        end
        repeat (20) @(posedge mclk);
        test_reset();
        test_arith();
        test_transfer();
        test_illegal();
        test_stall();
        test_reset_mid();
        close_out();
    end

endmodule

`default_nettype wire
